// [hw/adc_serial_mode_select_map.vh]
// Constants for the serial mode select block of the converter
// Function
// - Convert start rising edge samples select input: high select mode, low chain mode.
// - Select input tied to convert start yields chain mode when fast mode is low.
// - Chain mode works only with fast mode low; fast mode forces select mode.
// - Select mode: 3-wire uses convert start only; 4-wire also gates readback by select.
// - With fast mode low a start bit may precede the result as busy flag.
// - Busy flag armed only if start or select low at conversion end, fast low.
// - Readout allowed while convert start low, in conversion, acquisition or split.
// - Reference powerdown low enables internal reference; high powers it down.
// - Fast mode: no powerdown, first result invalid; normal mode powers down between.
// - Start rise begins an internally timed conversion; serial clock only shifts data.
// - Remaining result bits leave MSB first on successive serial clock falls.
`ifndef ADC_SERIAL_MODE_SELECT_MAP_VH
`define ADC_SERIAL_MODE_SELECT_MAP_VH

// ==========================================================
// Timing
`define CLK_MHZ        50
`define CONV_TIME_NS   500
`define CONV_CYC       ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)

// ==========================================================
// Register offsets (byte addresses)
`define REG_RESULT     8'h00
`define REG_STATUS     8'h04
`define REG_MASK       8'h08
`define REG_STATE      8'h0c

// ==========================================================
// Status and mask bit positions
`define ST_CONV_DONE   0
`define ST_READ_DONE   1
`define ST_FIRST_BAD   2
`define ST_W           3

// ==========================================================
// State register bit positions
`define SS_CHAIN       0
`define SS_CONVERTING  1
`define SS_BUSY_ARMED  2
`define SS_FAST        3
`define SS_SDO_OE      4
`define SS_POWERED_DN  5
`define SS_REF_EN      6

// ==========================================================
// Reset values
`define RESULT_RST     18'h00000
`define MASK_RST       3'h0

`endif

// [hw/adc_serial_mode_select.v]
// Serial interface mode select, conversion timing and readout of the converter
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`include "adc_serial_mode_select_map.vh"

module adc_serial_mode_select #(
    parameter RES_W = 18,
    parameter CNT_W = 8
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              reset,
    // Wishbone slave
    input  wire [7:0]        wb_adr_i,
    input  wire [31:0]       wb_dat_i,
    input  wire [3:0]        wb_sel_i,
    input  wire              wb_we_i,
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o,
    // Converter pins
    input  wire              convert_start,
    input  wire              select_or_chain_input,
    input  wire              sck,
    input  wire              fast_mode_select,
    input  wire              reference_powerdown,
    output reg               serial_data_out,
    output reg               serial_data_out_oe,
    // Analog control and interrupt
    output reg               ref_enable,
    output reg               powered_down,
    output reg               irq
);

    // ==========================================================
    // Pin synchronisers: bit 0 start, 1 select, 2 sck, 3 fast, 4 refpd
    reg  [4:0]       s1_r;
    reg  [4:0]       s2_r;
    reg  [4:0]       s3_r;

    // Left out of reset on purpose: the stages then mirror the pins when reset
    // ends, whereas cleared stages would fake a start edge on an idle-high pin
    always @(posedge mclk) begin
        s1_r <= {reference_powerdown, fast_mode_select, sck,
                 select_or_chain_input, convert_start};
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    wire cnv_s    = s2_r[0];
    wire sdi_s    = s2_r[1];
    wire fast_s   = s2_r[3];
    wire cnv_rise = s2_r[0] & ~s3_r[0];
    wire sck_fall = ~s2_r[2] & s3_r[2];

    // ==========================================================
    // Registers and state
    // Integer constants are cut to their register widths on purpose
    localparam integer     CONV_CYC_I = `CONV_CYC;
    localparam [CNT_W-1:0] CONV_CYC   = CONV_CYC_I[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam integer     LAST_I     = RES_W - 1;
    localparam [4:0]       LAST_BIT   = LAST_I[4:0];

    reg  [RES_W-1:0] result_r;
    reg  [RES_W-1:0] last_r;
    reg  [RES_W-1:0] shift_r;
    reg  [`ST_W-1:0] status_r;
    reg  [`ST_W-1:0] mask_r;
    reg  [CNT_W-1:0] conv_cnt_r;
    reg  [4:0]       left_r;
    reg              chain_r;
    reg              fast_lat_r;
    reg              fast_seen_r;
    reg              busy_r;
    reg              start_r;
    reg              sel_d_r;

    wire converting = (conv_cnt_r != {CNT_W{1'b0}});
    wire conv_end   = (conv_cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
    // 3-wire: start low selects; 4-wire: select input low also selects
    wire sel        = chain_r ? ~cnv_s : ~(cnv_s & sdi_s);
    wire sel_start  = sel & ~sel_d_r & ~serial_data_out_oe & ~start_r;
    wire busy_cond  = ~chain_r & ~fast_lat_r & (~cnv_s | ~sdi_s);
    wire read_last  = sck_fall & serial_data_out_oe & ~start_r & ~chain_r
                      & (left_r == 5'd0);

    wire bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr     = bus_req & wb_we_i;

    wire [`ST_W-1:0] ev;
    assign ev[`ST_CONV_DONE] = conv_end;
    assign ev[`ST_READ_DONE] = read_last;
    assign ev[`ST_FIRST_BAD] = cnv_rise & fast_s & ~fast_seen_r;

    // ==========================================================
    // Mode latch and conversion timer
    reg  [CNT_W-1:0] conv_cnt_nxt;

    // A start edge always restarts the count, even in mid-conversion
    always @* begin
        conv_cnt_nxt = conv_cnt_r;
        if (cnv_rise) begin
            conv_cnt_nxt = CONV_CYC;
        end else if (converting) begin
            conv_cnt_nxt = conv_cnt_r - CNT_ONE;
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            chain_r     <= 1'b0;
            fast_lat_r  <= 1'b0;
            fast_seen_r <= 1'b0;
            conv_cnt_r  <= {CNT_W{1'b0}};
            last_r      <= `RESULT_RST;
            busy_r      <= 1'b0;
        end else begin
            conv_cnt_r <= conv_cnt_nxt;
            if (cnv_rise) begin
                // Previous select level models the hold time, so a tied pin reads low
                chain_r     <= ~s3_r[1] & ~fast_s;
                fast_lat_r  <= fast_s;
                fast_seen_r <= fast_s;
                busy_r      <= 1'b0;
            end
            if (conv_end) begin
                last_r <= result_r;
                busy_r <= busy_cond;
            end
        end
    end

    // ==========================================================
    // Serial readout
    always @(posedge mclk) begin
        if (reset) begin
            shift_r            <= `RESULT_RST;
            left_r             <= 5'd0;
            start_r            <= 1'b0;
            sel_d_r            <= 1'b0;
            serial_data_out    <= 1'b0;
            serial_data_out_oe <= 1'b0;
        end else begin
            sel_d_r <= sel;
            if (cnv_rise & ~chain_r) begin
                serial_data_out_oe <= 1'b0;
                start_r            <= 1'b0;
            end else if (conv_end & busy_cond) begin
                // Start bit driven low; a pull-up turns it into a host interrupt
                shift_r            <= result_r;
                serial_data_out    <= 1'b0;
                serial_data_out_oe <= 1'b1;
                start_r            <= 1'b1;
            end else if (sel_start) begin
                // Data is that of the previous conversion, even mid-conversion
                shift_r            <= last_r;
                serial_data_out    <= last_r[RES_W-1];
                serial_data_out_oe <= 1'b1;
                left_r             <= LAST_BIT;
            end else if (~sel & ~start_r) begin
                serial_data_out_oe <= 1'b0;
            end else if (sck_fall & serial_data_out_oe) begin
                if (start_r) begin
                    start_r         <= 1'b0;
                    serial_data_out <= shift_r[RES_W-1];
                    left_r          <= LAST_BIT;
                end else if (read_last) begin
                    serial_data_out_oe <= 1'b0;
                end else begin
                    // Chain mode feeds the upstream part's data in behind ours
                    shift_r         <= {shift_r[RES_W-2:0], chain_r & sdi_s};
                    serial_data_out <= shift_r[RES_W-2];
                    if (left_r != 5'd0) begin
                        left_r <= left_r - 5'd1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Analog control outputs
    reg              ref_enable_nxt;
    reg              powered_down_nxt;

    always @* begin
        ref_enable_nxt   = ~s2_r[4];
        // Normal mode sleeps between conversions, fast mode stays awake
        powered_down_nxt = ~fast_s & ~converting;
    end

    always @(posedge mclk) begin
        if (reset) begin
            ref_enable   <= 1'b0;
            powered_down <= 1'b1;
        end else begin
            ref_enable   <= ref_enable_nxt;
            powered_down <= powered_down_nxt;
        end
    end

    // ==========================================================
    // Bus slave, sticky status and interrupt
    // Address decode for the write path; the read path decodes wb_adr_i in its own case
    wire             hit_result = (wb_adr_i == `REG_RESULT);
    wire             hit_status = (wb_adr_i == `REG_STATUS);
    wire             hit_mask   = (wb_adr_i == `REG_MASK);
    wire             bus_rd     = bus_req & ~wb_we_i;
    wire [6:0]       state_word = {ref_enable, powered_down, serial_data_out_oe,
                                   fast_lat_r, busy_r, converting, chain_r};

    reg  [RES_W-1:0] result_nxt;
    reg  [`ST_W-1:0] status_nxt;
    reg  [`ST_W-1:0] mask_nxt;
    reg  [31:0]      wb_dat_nxt;
    reg              irq_nxt;
    integer          i;

    // Next values of the software-visible registers
    always @* begin
        result_nxt = result_r;
        status_nxt = status_r;
        mask_nxt   = mask_r;
        if (bus_wr && hit_result) begin
            if (wb_sel_i[0]) begin
                result_nxt[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                result_nxt[15:8] = wb_dat_i[15:8];
            end
            if (wb_sel_i[2]) begin
                result_nxt[17:16] = wb_dat_i[17:16];
            end
        end
        if (bus_wr && hit_mask && wb_sel_i[0]) begin
            mask_nxt = wb_dat_i[`ST_W-1:0];
        end
        for (i = 0; i < `ST_W; i = i + 1) begin
            // A new event wins over a clear in the same cycle
            if (ev[i]) begin
                status_nxt[i] = 1'b1;
            end else if (bus_wr && hit_status && wb_sel_i[0] && wb_dat_i[i]) begin
                status_nxt[i] = 1'b0;
            end
        end
    end

    // Read data changes only on a read, so it holds until the next one
    always @* begin
        wb_dat_nxt = wb_dat_o;
        irq_nxt    = |(status_r & mask_r);
        if (bus_rd) begin
            case (wb_adr_i)
                `REG_RESULT: wb_dat_nxt = {14'h0000, result_r};
                `REG_STATUS: wb_dat_nxt = {29'h00000000, status_r};
                `REG_MASK:   wb_dat_nxt = {29'h00000000, mask_r};
                `REG_STATE:  wb_dat_nxt = {25'h0000000, state_word};
                default:     wb_dat_nxt = 32'h00000000;
            endcase
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            result_r <= `RESULT_RST;
            mask_r   <= `MASK_RST;
            status_r <= {`ST_W{1'b0}};
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            irq      <= 1'b0;
        end else begin
            // One-cycle ack; bus_req masks the request while ack is high
            wb_ack_o <= bus_req;
            result_r <= result_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            wb_dat_o <= wb_dat_nxt;
            irq      <= irq_nxt;
        end
    end

endmodule

// [bench/mode_sel_props.sv]
// Port-level checks of the converter serial mode select block
`timescale 1ns/100ps
module mode_sel_props (
    // Clock and reset
    input wire        mclk,
    input wire        reset,
    // Register bus
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0]  wb_sel_i,
    input wire        wb_we_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Pins and status
    input wire        convert_start,
    input wire        select_or_chain_input,
    input wire        fast_mode_select,
    input wire        reference_powerdown,
    input wire        serial_data_out_oe,
    input wire        ref_enable,
    input wire        powered_down,
    input wire        irq
);
    // ========
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_mask_off;
        s_req ##0 (wb_we_i && wb_adr_i == 8'h08 && wb_sel_i[0] && wb_dat_i[2:0] == 3'h0);
    endsequence
    property p_ack; s_req |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_unmapped;
        s_req ##0 (!wb_we_i && wb_adr_i[7:4] != 4'h0) |=> wb_dat_o == 32'h0;
    endproperty
    property p_irq_off; s_mask_off |-> ##2 !irq; endproperty
    property p_ref_on; !reference_powerdown [*6] |-> ref_enable; endproperty
    property p_ref_off; reference_powerdown [*6] |-> !ref_enable; endproperty
    property p_fast_up; fast_mode_select [*6] |-> !powered_down; endproperty
    property p_deselect;
        (convert_start && select_or_chain_input) [*5] |-> !serial_data_out_oe;
    endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_irq_off: assert property (p_irq_off) else $error("irq with mask cleared");
    a_ref_on: assert property (p_ref_on) else $error("reference off");
    a_ref_off: assert property (p_ref_off) else $error("reference on");
    a_fast_up: assert property (p_fast_up) else $error("powered down in fast mode");
    a_deselect: assert property (p_deselect) else $error("driving while deselected");
endmodule
bind adc_serial_mode_select mode_sel_props i_props (
    .mclk(mclk), .reset(reset), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .convert_start(convert_start),
    .select_or_chain_input(select_or_chain_input), .fast_mode_select(fast_mode_select),
    .reference_powerdown(reference_powerdown), .serial_data_out_oe(serial_data_out_oe),
    .ref_enable(ref_enable), .powered_down(powered_down), .irq(irq));

// [bench/host_model.sv]
// Behavioural host driving convert start, select and a gated serial clock
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire  mclk,
    // Converter pins
    input wire  serial_data_out,
    output reg  convert_start,
    output reg  select_or_chain_input,
    output reg  sck
);
    // ========
    // Pin sequences
    initial begin
        convert_start = 1'b1;
        select_or_chain_input = 1'b1;
        sck = 1'b0;
    end
    task conv(input s, input busy);
        begin
            select_or_chain_input <= s;
            convert_start <= 1'b0;
            repeat (2) @(posedge mclk);
            convert_start <= 1'b1;
            repeat (2) @(posedge mclk);
            if (busy) begin
                convert_start <= 1'b0;
            end
            repeat (32) @(posedge mclk);
        end
    endtask
    // Samples late in the high phase, well after the device moved the bit
    task rd(input int n, input four, output reg [18:0] bits);
        int i;
        begin
            bits = 19'h0;
            if (four) begin
                select_or_chain_input <= 1'b0;
            end else begin
                convert_start <= 1'b0;
            end
            repeat (6) @(posedge mclk);
            for (i = 0; i < n; i++) begin
                sck <= 1'b1;
                repeat (4) @(posedge mclk);
                bits = {bits[17:0], serial_data_out};
                sck <= 1'b0;
                repeat (4) @(posedge mclk);
            end
            select_or_chain_input <= 1'b1;
        end
    endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench of the converter serial mode select block
`timescale 1ns/100ps
module testbench;
    // ========
    // Signals
    reg         mclk, reset, wb_we_i, wb_cyc_i, wb_stb_i, fast_mode_select, reference_powerdown;
    reg [7:0]   wb_adr_i;
    reg [31:0]  wb_dat_i, seed, rd_q;
    reg [17:0]  model_res;
    reg [18:0]  bits;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o, convert_start, select_or_chain_input, sck, serial_data_out;
    wire        serial_data_out_oe, ref_enable, powered_down, irq;
    int         mismatches, samples_checked, k;
    adc_serial_mode_select i_dut (.mclk(mclk), .reset(reset), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck(sck),
        .convert_start(convert_start), .select_or_chain_input(select_or_chain_input),
        .fast_mode_select(fast_mode_select), .reference_powerdown(reference_powerdown),
        .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
        .ref_enable(ref_enable), .powered_down(powered_down), .irq(irq));
    host_model i_host (.mclk(mclk), .serial_data_out(serial_data_out), .sck(sck),
        .convert_start(convert_start), .select_or_chain_input(select_or_chain_input));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #400000;
        mismatches++;
        end_of_test;
    end
    // ========
    // Helpers
    function [31:0] xs(input [31:0] s);
        begin
            s = s ^ (s << 13);
            s = s ^ (s >> 17);
            xs = s ^ (s << 5);
        end
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            samples_checked++;
            if (g !== e) begin
                $display("mismatch %s expected %h seen %h", nm, e, g);
                mismatches++;
            end
        end
    endtask
    task wb(input [7:0] a, input w, input [31:0] d);
        int n;
        begin
            n = 0;
            wb_adr_i <= a;
            wb_we_i <= w;
            wb_dat_i <= d;
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            @(posedge mclk);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                @(posedge mclk);
                n++;
            end
            rd_q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge mclk);
            if (n == 20) begin
                $display("mismatch wb_ack expected 1 seen 0");
                mismatches++;
            end
            if (w && a == 8'h00)
                model_res = d[17:0];
        end
    endtask
    task end_of_test;
        begin
            if (mismatches == 0 && samples_checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // ========
    // Scenarios
    initial begin
        {reset, wb_we_i, wb_cyc_i, wb_stb_i, fast_mode_select, reference_powerdown} = 6'h20;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        mismatches = 0;
        samples_checked = 0;
        seed = 32'h64dd812a;
        model_res = 18'h0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        wb(8'h0c, 1'b0, 32'h0);
        chk("state", 32'h60, rd_q & 32'h60);
        // Kinds: 3-wire, 3-wire with start bit, 4-wire
        for (k = 0; k < 3; k++) begin
            seed = xs(seed);
            wb(8'h00, 1'b1, seed);
            i_host.conv(1'b1, k == 1);
            wb(8'h0c, 1'b0, 32'h0);
            chk("busy_armed", (k == 1) ? 32'h4 : 32'h0, rd_q & 32'h4);
            i_host.rd(k == 1 ? 19 : 18, k == 2, bits);
            repeat (2) @(posedge mclk);
            chk("readout", {13'h0, 1'b0, model_res}, {13'h0, bits});
            chk("sdo_oe", 32'h0, {31'h0, serial_data_out_oe});
            wb(8'h04, 1'b0, 32'h0);
            chk("status", 32'h3, rd_q);
            wb(8'h08, 1'b1, 32'h3);
            chk("irq_on", 32'h1, {31'h0, irq});
            wb(8'h04, 1'b1, 32'h7);
            wb(8'h08, 1'b1, 32'h0);
            chk("irq_off", 32'h0, {31'h0, irq});
        end
        i_host.conv(1'b0, 1'b0);
        wb(8'h0c, 1'b0, 32'h0);
        chk("chain", 32'h1, rd_q & 32'h1);
        i_host.select_or_chain_input <= 1'b1;
        repeat (4) @(posedge mclk);
        wb(8'h0c, 1'b0, 32'h0);
        chk("chain_held", 32'h1, rd_q & 32'h1);
        fast_mode_select <= 1'b1;
        repeat (8) @(posedge mclk);
        i_host.conv(1'b0, 1'b0);
        wb(8'h0c, 1'b0, 32'h0);
        chk("fast_state", 32'h8, rd_q & 32'h9);
        wb(8'h04, 1'b0, 32'h0);
        chk("first_bad", 32'h4, rd_q & 32'h4);
        fast_mode_select <= 1'b0;
        reference_powerdown <= 1'b1;
        repeat (8) @(posedge mclk);
        wb(8'h0c, 1'b0, 32'h0);
        chk("ref_off", 32'h0, rd_q & 32'h40);
        wb(8'h10, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd_q);
        wb(8'h00, 1'b0, 32'h0);
        chk("result", {14'h0, model_res}, rd_q);
        end_of_test;
    end
endmodule
